/* File: hdl/acs_pkg.sv */
// Package: constants of the channel-select serial control block
package acs_pkg;
   localparam int ACS_FRAME_BITS = 16;
   localparam int ACS_CMD_BITS = 8;
   localparam int ACS_ZERO_LEAD = 4;
   localparam int ACS_RES_BITS = 12;
   localparam int ACS_CHAN_MSB = 5;
   localparam int ACS_CHAN_LSB = 3;
   localparam int ACS_TRACK_EDGES = 3;
   localparam logic [2:0] ACS_CHAN_RST = 3'h0;
   localparam logic [4:0] ACS_CNT_ZERO = 5'h00;
   localparam logic [4:0] ACS_CNT_ONE = 5'h01;
   localparam logic [4:0] ACS_CNT_CMD = 5'h08;
   localparam logic [4:0] ACS_CNT_LEAD = 5'h04;
   localparam logic [4:0] ACS_CNT_FULL = 5'h10;
   localparam logic [11:0] ACS_RES_ZERO = 12'h000;
   localparam logic [7:0] ACS_CMD_ZERO = 8'h00;
endpackage : acs_pkg

/* File: hdl/acs_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module acs_sync #(
   parameter logic INIT = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic d_i,
   output logic q_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } acs_sync_s;
   acs_sync_s st_r;
   acs_sync_s st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = d_i;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // Only accept once the last two stages agree
      if (st_r.s2 == st_r.s3) begin
         st_nxt.q = st_r.s3;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= {INIT, INIT, INIT, INIT};
      end else begin
         st_r <= st_nxt;
      end
   end
   assign q_o = st_r.q;
endmodule : acs_sync

/* File: hdl/acs_serial_ctrl.sv */
// Serial control of an eight-input converter: command, framing, power, result shift
`timescale 1ns/1ps
module acs_serial_ctrl
   import acs_pkg::*;
#(
   parameter int RES_W = ACS_RES_BITS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic chip_select_bar_i,
   input wire logic sclk_i,
   input wire logic din_i,
   input wire logic [RES_W-1:0] conv_result_i,
   output logic dout_o,
   output logic dout_oe_o,
   output logic [2:0] mux_sel_o,
   output logic track_o,
   output logic powered_o,
   output logic sample_strobe_o
);
   typedef enum logic [2:0] {
      ACS_IDLE = 3'b001,
      ACS_TRACK = 3'b010,
      ACS_CONV = 3'b100
   } acs_state_e;

   typedef struct packed {
      acs_state_e state;
      logic sclk_d;
      logic [4:0] rise_cnt;
      logic [4:0] fall_cnt;
      logic [7:0] cmd_sh;
      logic [2:0] chan_next;
      logic [2:0] chan_cur;
      logic [RES_W-1:0] res_sh;
      logic dout;
      logic oe;
      logic track;
      logic powered;
      logic strobe;
   } acs_s;

   acs_s st_r;
   acs_s st_nxt;
   logic cs_n_s;
   logic sclk_s;
   logic din_s;

   acs_sync #(.INIT(1'b1)) u_sync_cs (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(chip_select_bar_i),
      .q_o(cs_n_s)
   );
   acs_sync #(.INIT(1'b0)) u_sync_sclk (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(sclk_i),
      .q_o(sclk_s)
   );
   // Same depth as the clock path, so data and clock edge stay aligned
   acs_sync #(.INIT(1'b0)) u_sync_din (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(din_i),
      .q_o(din_s)
   );

   function automatic logic [2:0] chan_field(input logic [7:0] cmd);
      chan_field = cmd[ACS_CHAN_MSB:ACS_CHAN_LSB];
   endfunction : chan_field

   logic rise_e;
   logic fall_e;
   logic [7:0] cmd_shift;
   always_comb begin
      rise_e = sclk_s & ~st_r.sclk_d;
      fall_e = ~sclk_s & st_r.sclk_d;
      cmd_shift = {st_r.cmd_sh[ACS_CMD_BITS-2:0], din_s};
      st_nxt = st_r;
      st_nxt.sclk_d = sclk_s;
      st_nxt.strobe = 1'b0;
      if (cs_n_s) begin
         // Clock gated and output released while deselected
         st_nxt.state = ACS_IDLE;
         st_nxt.rise_cnt = ACS_CNT_ZERO;
         st_nxt.fall_cnt = ACS_CNT_ZERO;
         st_nxt.oe = 1'b0;
         st_nxt.dout = 1'b0;
         st_nxt.track = 1'b0;
         st_nxt.powered = 1'b0;
      end else begin
         unique case (st_r.state)
            ACS_IDLE: begin
               // Frame start; a low clock at select counts as first falling edge
               st_nxt.state = ACS_TRACK;
               st_nxt.powered = 1'b1;
               st_nxt.oe = 1'b1;
               st_nxt.track = 1'b1;
               st_nxt.chan_cur = st_r.chan_next;
               st_nxt.res_sh = RES_W'(ACS_RES_ZERO);
               st_nxt.dout = 1'b0;
               st_nxt.fall_cnt = sclk_s ? ACS_CNT_ZERO : ACS_CNT_ONE;
            end
            ACS_TRACK, ACS_CONV: begin
               if (rise_e) begin
                  if (st_r.rise_cnt < ACS_CNT_CMD) begin
                     st_nxt.cmd_sh = cmd_shift;
                  end
                  if (st_r.rise_cnt == ACS_CNT_CMD - ACS_CNT_ONE) begin
                     st_nxt.chan_next = chan_field(cmd_shift);
                  end
                  if (st_r.rise_cnt == ACS_CNT_FULL - ACS_CNT_ONE) begin
                     st_nxt.rise_cnt = ACS_CNT_ZERO;
                  end else begin
                     st_nxt.rise_cnt = st_r.rise_cnt + ACS_CNT_ONE;
                  end
               end
               if (fall_e) begin
                  if (st_r.fall_cnt == ACS_CNT_FULL) begin
                     // Next conversion of a continuous frame: wake and track again
                     st_nxt.fall_cnt = ACS_CNT_ONE;
                     st_nxt.powered = 1'b1;
                     st_nxt.state = ACS_TRACK;
                     st_nxt.track = 1'b1;
                     st_nxt.chan_cur = st_r.chan_next;
                     st_nxt.dout = 1'b0;
                  end else begin
                     st_nxt.fall_cnt = st_r.fall_cnt + ACS_CNT_ONE;
                     if (st_r.fall_cnt + ACS_CNT_ONE == ACS_CNT_LEAD) begin
                        // Hold: result captured here, zeros still leading
                        st_nxt.state = ACS_CONV;
                        st_nxt.track = 1'b0;
                        st_nxt.res_sh = conv_result_i;
                        st_nxt.strobe = 1'b1;
                        st_nxt.dout = 1'b0;
                     end else if (st_r.fall_cnt + ACS_CNT_ONE > ACS_CNT_LEAD) begin
                        st_nxt.dout = st_r.res_sh[RES_W-1];
                        st_nxt.res_sh = {st_r.res_sh[RES_W-2:0], 1'b0};
                     end else begin
                        st_nxt.dout = 1'b0;
                     end
                     if (st_r.fall_cnt + ACS_CNT_ONE == ACS_CNT_FULL) begin
                        st_nxt.powered = 1'b0;
                     end
                  end
               end
            end
            default: begin
               st_nxt.state = ACS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '{state: ACS_IDLE, sclk_d: 1'b0, rise_cnt: ACS_CNT_ZERO,
                   fall_cnt: ACS_CNT_ZERO, cmd_sh: ACS_CMD_ZERO,
                   chan_next: ACS_CHAN_RST, chan_cur: ACS_CHAN_RST,
                   res_sh: RES_W'(ACS_RES_ZERO), dout: 1'b0, oe: 1'b0, track: 1'b0,
                   powered: 1'b0, strobe: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dout_o = st_r.dout;
   assign dout_oe_o = st_r.oe;
   assign mux_sel_o = st_r.chan_cur;
   assign track_o = st_r.track;
   assign powered_o = st_r.powered;
   assign sample_strobe_o = st_r.strobe;

   a_idle_unpowered: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_r.state == ACS_IDLE) |-> !powered_o && !dout_oe_o)
      else $error("powered or driving while deselected");
   a_desel_release: assert property (@(posedge clk_i) disable iff (rst_i)
      cs_n_s |=> !dout_oe_o)
      else $error("output enabled after deselect");
   a_chan_stable: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_r.state == ACS_CONV) && $stable(st_r.state) |-> $stable(mux_sel_o))
      else $error("channel changed during conversion");
   a_chan_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      !cs_n_s && rise_e && st_r.rise_cnt == ACS_CNT_CMD - ACS_CNT_ONE |=>
      st_r.chan_next == $past(cmd_shift[ACS_CHAN_MSB:ACS_CHAN_LSB]))
      else $error("channel field not latched after eighth bit");
   a_lead_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      dout_oe_o && st_r.fall_cnt <= ACS_CNT_LEAD |-> !dout_o)
      else $error("leading zero missing");
   a_frame_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.rise_cnt <= 5'h0F)
      else $error("conversion exceeded sixteen clocks");
   a_auto_pdown: assert property (@(posedge clk_i) disable iff (rst_i)
      !cs_n_s && fall_e && st_r.fall_cnt == 5'h0F |=> !powered_o)
      else $error("no power-down after sixteenth falling edge");
   a_wake_track: assert property (@(posedge clk_i) disable iff (rst_i)
      !cs_n_s && fall_e && st_r.fall_cnt == ACS_CNT_FULL && st_r.state != ACS_IDLE
      |=> powered_o && track_o)
      else $error("no wake on next first falling edge");
   a_ignore_bits: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(st_r.chan_next) |-> $past(rise_e) && $past(st_r.rise_cnt) == 5'h07)
      else $error("channel changed outside field latch");

   a_hold_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
      sample_strobe_o |-> st_r.state == ACS_CONV && st_r.fall_cnt == ACS_CNT_LEAD)
      else $error("result captured outside the fourth falling edge");
   a_low_clk_start: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.state == ACS_IDLE && !cs_n_s && !sclk_s |=> st_r.fall_cnt == ACS_CNT_ONE)
      else $error("select with clock low not counted as first fall");
endmodule : acs_serial_ctrl

/* File: verif/acs_host_model.sv */
// Host model: drives chip select, serial clock and command, collects result bits
`timescale 1ns/1ps
module acs_host_model (
   input wire logic clk_i,
   input wire logic dout_i,
   input wire logic dout_oe_i,
   output logic chip_select_bar_o,
   output logic sclk_o,
   output logic din_o,
   output logic [4:0] fall_n_o,
   output logic smp_o
);
   // Half sclk period in clk cycles, kept above the 7-cycle minimum
   localparam int HALF = 8;
   logic dout_w;
   // No pull on the line, so an undriven read shows z and never matches
   assign dout_w = dout_oe_i ? dout_i : 1'bz;
   initial begin
      chip_select_bar_o = 1'b1;
      sclk_o = 1'b1;
      din_o = 1'b0;
      fall_n_o = 5'h00;
      smp_o = 1'b0;
   end
   // With sclk parked high fall 1 is a real sclk fall; with it parked low the select edge stands for fall 1
   task automatic sel(input logic on);
      chip_select_bar_o <= ~on;
      din_o <= ~din_o;
      fall_n_o <= 5'h00;
      repeat (HALF) @(posedge clk_i);
   endtask : sel
   task automatic conv(input logic [7:0] cmd, output logic [15:0] rd);
      rd = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         sclk_o <= 1'b0;
         din_o <= (i < 8) ? cmd[7-i] : ~din_o;
         fall_n_o <= 5'(i + 1);
         repeat (HALF - 1) @(posedge clk_i);
         smp_o <= 1'b1;
         rd = {rd[14:0], dout_w};
         @(posedge clk_i);
         smp_o <= 1'b0;
         sclk_o <= 1'b1;
         repeat (HALF) @(posedge clk_i);
      end
   endtask : conv
   // Edges while deselected, which must leave no trace
   task automatic stray(input int n);
      repeat (n) begin
         sclk_o <= ~sclk_o;
         din_o <= ~din_o;
         repeat (HALF) @(posedge clk_i);
      end
   endtask : stray
endmodule : acs_host_model

/* File: verif/tb_top.sv */
// Testbench: host frames against the serial control block
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cs_bar, sclk, din, dout, dout_oe, track, powered, smp;
   logic [11:0] conv_result = 12'h000;
   logic [2:0] mux_sel;
   logic [2:0] exp_ch = 3'h0;
   logic [4:0] fall_n;
   logic strobe;
   int n_strobe = 0;
   logic [15:0] rd;
   int err_count = 0;
   int n_checks = 0;
   always #12.5 clk_i = ~clk_i;
   acs_serial_ctrl u_acs_serial_ctrl (.clk_i(clk_i), .rst_i(rst_i),
      .chip_select_bar_i(cs_bar), .sclk_i(sclk), .din_i(din), .conv_result_i(conv_result),
      .dout_o(dout), .dout_oe_o(dout_oe), .mux_sel_o(mux_sel), .track_o(track),
      .powered_o(powered), .sample_strobe_o(strobe));
   acs_host_model u_host (.clk_i(clk_i), .dout_i(dout), .dout_oe_i(dout_oe),
      .chip_select_bar_o(cs_bar), .sclk_o(sclk), .din_o(din), .fall_n_o(fall_n), .smp_o(smp));
   // Analog core stand-in: result carries the selected input index
   always @(posedge clk_i) conv_result <= {mux_sel, 9'h15A};
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done
   // Ignored bits change with the field, so a leak shows up
   function automatic logic [7:0] cmd_of(input logic [2:0] k);
      return {~k[1:0], k, k};
   endfunction : cmd_of
   always @(posedge clk_i) begin
      if (strobe) begin
         n_strobe++;
      end
      if (smp) begin
         chk("powered", 16'(powered), 16'(fall_n != 5'h10));
         chk("track", 16'(track), 16'(fall_n <= 5'h03));
         chk("mux_sel", 16'(mux_sel), 16'(exp_ch));
         chk("dout_oe", 16'(dout_oe), 16'h0001);
      end
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      u_host.sel(1'b1);
      u_host.conv(cmd_of(3'h5), rd);
      chk("dummy word", rd, 16'h015A);
      for (int k = 0; k < 8; k++) begin
         exp_ch = (k == 0) ? 3'h5 : 3'(k - 1);
         u_host.conv(cmd_of(3'(k)), rd);
         chk("word", rd, {4'h0, exp_ch, 9'h15A});
      end
      u_host.sel(1'b0);
      chk("dout_oe idle", 16'(dout_oe), 16'h0000);
      chk("powered idle", 16'(powered), 16'h0000);
      u_host.stray(16);
      repeat (200) @(posedge clk_i);
      exp_ch = 3'h7;
      u_host.sel(1'b1);
      u_host.conv(cmd_of(3'h2), rd);
      chk("word after idle", rd, 16'h0F5A);
      u_host.sel(1'b0);
      // Park the serial clock low so the select edge stands for fall 1
      u_host.stray(1);
      exp_ch = 3'h2;
      u_host.sel(1'b1);
      u_host.conv(cmd_of(3'h4), rd);
      chk("word clock low", rd, 16'h055A);
      u_host.sel(1'b0);
      chk("strobes", 16'(n_strobe), 16'h000B);
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      err_count++;
      $display("mismatch watchdog expected end seen hang");
      test_done();
   end
endmodule : tb_top
